// ### shared/tcrb_pkg.sv
// Shared constants and carrier types of the transmit credit and reorder
// buffer block.
// Assumes a single 40 MHz clock and a classic Wishbone register bus.
package tcrb_pkg;

  // ------------------------------------------------------------------
  // Structure and timing
  // ------------------------------------------------------------------
  localparam int unsigned NUM_GRP         = 4;      // Buffer groups
  localparam int unsigned LBUF_DEPTH      = 8;      // Logical entries
  localparam int unsigned PBUF_DEPTH      = 8;      // Physical entries
  localparam int unsigned FIRST_TRIES_DEF = 256;    // First packet tries
  localparam int unsigned LATER_TRIES_DEF = 65536;  // Later packet tries
  localparam logic [3:0]  CREDIT_INIT     = 4'h8;   // Credit at reset
  localparam logic [3:0]  PBUF_FULL       = 4'h8;   // Physical room
  localparam logic [1:0]  PRIO_MAX        = 2'h3;   // Top priority
  localparam logic [2:0]  CODE_NO_CREDIT  = 3'h7;   // Completion code

  // ------------------------------------------------------------------
  // Register map and fields
  // ------------------------------------------------------------------
  localparam logic [7:0]  ADR_SETTINGS    = 8'h20;  // Settings control
  localparam logic [7:0]  ADR_CREDIT_STAT = 8'h24;  // Credit status
  localparam logic [7:0]  ADR_LS_STAT     = 8'h28;  // Load/store status
  localparam logic [31:0] SETTINGS_RST    = 32'h0000_0000;
  localparam int unsigned SET_THR_RESP    = 0;      // Response threshold
  localparam int unsigned SET_THR_REQ     = 4;      // Request threshold
  localparam int unsigned SET_SINGLE_PORT = 8;      // One port in use

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    UNIT_MAU, UNIT_RXU, UNIT_TXU, UNIT_LSU
  } tcrb_unit_t;

  typedef enum logic {TX_IDLE, TX_WAIT} tcrb_tx_t;

  typedef struct packed {
    logic [1:0] prio;                               // Packet priority
    logic [7:0] tag;                                // Packet handle
  } tcrb_pkt_t;

  typedef struct packed {
    logic       valid;                              // Credit request
    tcrb_unit_t unit;                               // Requesting unit
    logic [1:0] prio;                               // Wanted priority
    logic [1:0] port;                               // Target port
    logic       first;                              // First packet
    logic [7:0] tag;                                // Packet handle
  } tcrb_req_t;

  typedef struct packed {
    logic       grant;                              // Credit given
    logic       refuse;                             // Try again
    logic       giveUp;                             // Tries exhausted
    logic       skipQueue;                          // Move to next queue
    logic [2:0] code;                               // Completion code
    logic [1:0] prio;                               // Priority to use
  } tcrb_ans_t;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tcrb_wbreq_t;

endpackage

// ### rtl/tcrb_top.sv
// Transmit credit counters, logical buffer groups and the reordering
// physical transmit buffer, with a Wishbone register slave.
// Assumes request, link and bus inputs come from logic on sys_clk.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/100ps

// Operation
// - Multi-port mode: per-port groups, eight deep
// - Per-group credit, reset eight, minus per packet
// - Group pulses release on move to physical
// - Software thresholds in settings govern credit grants
// - Physical buffer accepts in order, room-limited
// - FIFO send; retry picks earliest highest priority
// - No higher priority queued: resend retried packet
// - After reordered success resend original; retry reruns
// - Single-port mode: per-priority groups, eight deep
// - Single-port arbiter drains highest priority first
// - Zero credit means no grant until release
// - Response units promote priority, then retry forever
// - Load/store single packet: 256 tries, code 111b
// - Load/store first of many: 256 tries, 111b
// - Load/store later packets: 64K tries, 111b
// - Message transmit credit requests are always bounded
// - Single-segment message: 256 tries, next queue
// - First segment: 256 tries, next queue
// - Later segments: 64K tries, code 111b, cancel
module tcrb_top #(
  parameter int unsigned FIRST_TRIES = tcrb_pkg::FIRST_TRIES_DEF,
  parameter int unsigned LATER_TRIES = tcrb_pkg::LATER_TRIES_DEF
) (
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 ce,
  input  wire tcrb_pkg::tcrb_wbreq_t wbReq,
  output      logic                 wbAck,
  output      logic [31:0]          wbDatOut,
  input  wire tcrb_pkg::tcrb_req_t  creditReq,
  output      tcrb_pkg::tcrb_ans_t  creditAns,
  output      logic [3:0]           bufRelease,
  output      logic                 txValid,
  output      tcrb_pkg::tcrb_pkt_t  txPkt,
  input  wire logic                 txOk,
  input  wire logic                 txRetry,
  output      logic [2:0]           lsStatusCode
);
  import tcrb_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [31:0]                settings;  // Settings control word
    tcrb_pkt_t [3:0][7:0]       lbuf;      // Logical buffer groups
    logic [3:0][2:0]            lwp;       // Group write pointers
    logic [3:0][2:0]            lrp;       // Group read pointers
    logic [3:0][3:0]            lcnt;      // Group fill levels
    logic [3:0][3:0]            credit;    // Credit per group
    tcrb_pkt_t [7:0]            pbuf;      // Physical buffer, head at 0
    logic [3:0]                 pcnt;      // Physical fill level
    logic [2:0]                 pick;      // Next entry to send
    logic [2:0]                 txIdx;     // Entry on the link
    tcrb_tx_t                   phase;     // Link phase
    logic                       txValid;   // Packet offered to link
    tcrb_pkt_t                  txPkt;     // Packet on the link
    logic [16:0]                tries;     // Refused credit requests
    tcrb_ans_t                  ans;       // Answer pulse
    logic [1:0]                 ansGrp;    // Group of the answer
    tcrb_unit_t                 ansUnit;   // Unit of the answer
    logic                       ansFirst;  // First-packet answer
    logic [3:0]                 rel;       // Release pulses
    logic [2:0]                 lsCode;    // Load/store status word
    logic                       wbAck;     // Bus acknowledge
    logic [31:0]                wbDat;     // Bus read data
  } tcrb_state_t;

  tcrb_state_t s_r;                        // Registered state
  tcrb_state_t s_nxt;                      // Next state

  logic        singleMode;                 // One port in use
  logic        respUnit;                   // Requester sends responses
  logic [1:0]  reqGrp;                     // Group the request targets
  logic [3:0]  thr;                        // Applicable threshold
  logic        reqOk;                      // Credit may be granted
  logic        take;                       // Request taken this cycle
  logic [16:0] limit;                      // Tries allowed
  logic [3:0]  grantG;                     // Grant per group
  logic        drainAny;                   // Some group holds a packet
  logic [1:0]  drainGrp;                   // Group chosen to drain
  logic        higherQueued;               // Helper for checks only
  logic [3:0]  grantCred;                  // Asked group credit, checks

  // Earliest entry of the highest priority above the head's; head if none
  function automatic logic [2:0] pick_next(input tcrb_pkt_t [7:0] b,
                                           input logic [3:0] cnt);
    logic [2:0] best;
    logic [1:0] bestPrio;
    best     = 3'h0;
    bestPrio = b[0].prio;
    for (int i = 1; i < 8; i++) begin
      // Strict compare keeps the earliest of equal priorities
      if (4'(i) < cnt && b[i].prio > bestPrio) begin
        best     = 3'(i);
        bestPrio = b[i].prio;
      end
    end
    return best;
  endfunction

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  // Bus slave, credit grant, link handling and drain in one pass
  always_comb begin
    s_nxt      = s_r;
    s_nxt.ans  = '0;
    s_nxt.rel  = '0;
    s_nxt.wbAck = 1'b0;
    s_nxt.wbDat = 32'h0000_0000;
    grantG     = 4'h0;
    drainAny   = 1'b0;
    drainGrp   = 2'h0;
    singleMode = s_r.settings[SET_SINGLE_PORT];

    // Register access; unmapped addresses read zero
    if (wbReq.cyc && wbReq.stb && !s_r.wbAck) begin
      s_nxt.wbAck = 1'b1;
      if (wbReq.adr == ADR_SETTINGS) begin
        s_nxt.wbDat = s_r.settings;
        if (wbReq.we) begin
          for (int b = 0; b < 4; b++) begin
            if (wbReq.sel[b]) begin
              s_nxt.settings[8*b +: 8] = wbReq.dat[8*b +: 8];
            end
          end
        end
      end else if (wbReq.adr == ADR_CREDIT_STAT) begin
        s_nxt.wbDat = {12'h000, s_r.pcnt, s_r.credit};
      end else if (wbReq.adr == ADR_LS_STAT) begin
        s_nxt.wbDat = {29'h0, s_r.lsCode};
      end
    end

    // Group choice: port in multi-port mode, priority otherwise
    reqGrp   = singleMode ? creditReq.prio : creditReq.port;
    respUnit = (creditReq.unit == UNIT_MAU) ||
               (creditReq.unit == UNIT_RXU);
    thr      = respUnit ? s_r.settings[SET_THR_RESP +: 4]
                        : s_r.settings[SET_THR_REQ +: 4];
    reqOk    = (s_r.credit[reqGrp] != 4'h0) &&
               (s_r.credit[reqGrp] > thr);
    limit    = creditReq.first ? 17'(FIRST_TRIES) : 17'(LATER_TRIES);
    take     = creditReq.valid &&
               !(s_r.ans.grant || s_r.ans.refuse || s_r.ans.giveUp);

    // One credit request per two cycles, answered by a pulse
    if (take) begin
      s_nxt.ansGrp   = reqGrp;
      s_nxt.ansUnit  = creditReq.unit;
      s_nxt.ansFirst = creditReq.first;
      s_nxt.ans.prio = creditReq.prio;
      if (reqOk) begin
        // Credit taken: packet enters its logical group
        s_nxt.ans.grant = 1'b1;
        s_nxt.tries     = 17'h0;
        grantG[reqGrp]  = 1'b1;
        s_nxt.lbuf[reqGrp][s_r.lwp[reqGrp]] = {creditReq.prio,
                                               creditReq.tag};
        s_nxt.lwp[reqGrp]  = s_r.lwp[reqGrp] + 3'h1;
        s_nxt.lcnt[reqGrp] = s_r.lcnt[reqGrp] + 4'h1;
        if (creditReq.unit == UNIT_LSU) begin
          s_nxt.lsCode = 3'h0;
        end
      end else if (respUnit) begin
        // Responses climb in priority and never give up
        s_nxt.ans.refuse = 1'b1;
        s_nxt.tries      = 17'h0;
        if (creditReq.prio != PRIO_MAX) begin
          s_nxt.ans.prio = creditReq.prio + 2'h1;
        end
      end else if (s_r.tries + 17'h1 >= limit) begin
        // Tries exhausted: bounded so no unit can deadlock
        s_nxt.ans.giveUp = 1'b1;
        s_nxt.tries      = 17'h0;
        if (creditReq.unit == UNIT_LSU) begin
          s_nxt.ans.code = CODE_NO_CREDIT;
          s_nxt.lsCode   = CODE_NO_CREDIT;
        end else if (creditReq.first) begin
          s_nxt.ans.skipQueue = 1'b1;
        end else begin
          s_nxt.ans.code = CODE_NO_CREDIT;
        end
      end else begin
        // Plain refusal, counted toward the limit
        s_nxt.ans.refuse = 1'b1;
        s_nxt.tries      = s_r.tries + 17'h1;
      end
    end

    // Link outcome: success removes the entry, retry reorders
    if (s_r.phase == TX_WAIT && (txOk || txRetry)) begin
      s_nxt.phase   = TX_IDLE;
      s_nxt.txValid = 1'b0;
      if (txOk) begin
        for (int i = 0; i < 7; i++) begin
          if (3'(i) >= s_r.txIdx) begin
            s_nxt.pbuf[i] = s_r.pbuf[i+1];
          end
        end
        s_nxt.pcnt = s_r.pcnt - 4'h1;
        s_nxt.pick = 3'h0;
      end else begin
        s_nxt.pick = pick_next(s_r.pbuf, s_r.pcnt);
      end
    end else if (s_r.phase == TX_IDLE && s_r.pcnt != 4'h0) begin
      // Offer the chosen entry, head first unless reordering
      s_nxt.phase   = TX_WAIT;
      s_nxt.txValid = 1'b1;
      s_nxt.txIdx   = s_r.pick;
      s_nxt.txPkt   = s_r.pbuf[s_r.pick];
    end

    // Drain arbiter: top priority in single-port mode, low port else
    if (singleMode) begin
      for (int g = 0; g < 4; g++) begin
        if (s_r.lcnt[g] != 4'h0) begin
          drainAny = 1'b1;
          drainGrp = 2'(g);
        end
      end
    end else begin
      for (int g = 3; g >= 0; g--) begin
        if (s_r.lcnt[g] != 4'h0) begin
          drainAny = 1'b1;
          drainGrp = 2'(g);
        end
      end
    end
    if (drainAny && s_nxt.pcnt < PBUF_FULL) begin
      // Append in arrival order, only while physical room remains
      s_nxt.pbuf[s_nxt.pcnt[2:0]] = s_r.lbuf[drainGrp][s_r.lrp[drainGrp]];
      s_nxt.pcnt           = s_nxt.pcnt + 4'h1;
      s_nxt.lrp[drainGrp]  = s_r.lrp[drainGrp] + 3'h1;
      s_nxt.lcnt[drainGrp] = s_nxt.lcnt[drainGrp] - 4'h1;
      s_nxt.rel[drainGrp]  = 1'b1;
    end

    // Credit: minus a grant, plus a release, capped at eight
    for (int g = 0; g < 4; g++) begin
      s_nxt.credit[g] = s_r.credit[g] - {3'h0, grantG[g]}
                        + {3'h0, s_nxt.rel[g]};
      if (s_nxt.credit[g] > CREDIT_INIT) begin
        s_nxt.credit[g] = CREDIT_INIT;
      end
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  // Asynchronous reset to constants; clock enable freezes all state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_r          <= '0;
      s_r.settings <= SETTINGS_RST;
      s_r.credit   <= {4{CREDIT_INIT}};
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // Outputs taken straight from state flops
  assign wbAck        = s_r.wbAck;
  assign wbDatOut     = s_r.wbDat;
  assign creditAns    = s_r.ans;
  assign bufRelease   = s_r.rel;
  assign txValid      = s_r.txValid;
  assign txPkt        = s_r.txPkt;
  assign lsStatusCode = s_r.lsCode;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  // Whether any queued entry beats the head; read by checks only
  assign higherQueued = (pick_next(s_r.pbuf, s_r.pcnt) != 3'h0);

  // Credit of the requested group as the request is taken; a past
  // value indexed by the answer's own group would read another group
  assign grantCred = s_r.credit[reqGrp];

  sequence seq_reordered_ok;
    s_r.txValid && txOk && (s_r.txIdx != 3'h0);
  endsequence

  sequence seq_head_retry;
    s_r.txValid && txRetry && !txOk && !higherQueued;
  endsequence

  a_credit_cap: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    s_r.credit[0] <= CREDIT_INIT && s_r.credit[3] <= CREDIT_INIT)
    else $error("credit counter above eight");

  a_grant_credit: assert property (
    @(posedge sys_clk) disable iff (!resetn || !ce)
    s_r.ans.grant |-> $past(grantCred) != 4'h0)
    else $error("credit granted from empty counter");

  a_credit_dec: assert property (
    @(posedge sys_clk) disable iff (!resetn || !ce)
    s_r.ans.grant && !s_r.rel[s_r.ansGrp] |->
      s_r.credit[s_r.ansGrp] == $past(grantCred) - 4'h1)
    else $error("grant did not take one credit");

  a_release_credit: assert property (
    @(posedge sys_clk) disable iff (!resetn || !ce)
    s_r.rel[1] && !(s_r.ans.grant && s_r.ansGrp == 2'h1) |->
      s_r.credit[1] == $past(s_r.credit[1]) + 4'h1)
    else $error("release did not return credit");

  a_drain_prio: assert property (
    @(posedge sys_clk) disable iff (!resetn || !ce)
    s_r.rel[0] && s_r.settings[SET_SINGLE_PORT] |->
      $past(s_r.lcnt[3]) == 4'h0 && $past(s_r.lcnt[2]) == 4'h0 &&
      $past(s_r.lcnt[1]) == 4'h0)
    else $error("lower priority drained first");

  a_phys_room: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    s_r.pcnt <= PBUF_FULL && s_r.lcnt[2] <= 4'(LBUF_DEPTH))
    else $error("buffer overfilled");

  a_reorder_prio: assert property (
    @(posedge sys_clk) disable iff (!resetn || !ce)
    $rose(s_r.txValid) && s_r.txIdx != 3'h0 |->
      s_r.txPkt.prio > s_r.pbuf[0].prio)
    else $error("reordered packet not of higher priority");

  a_resend_head: assert property (
    @(posedge sys_clk) disable iff (!resetn || !ce)
    seq_head_retry |-> ##2 s_r.txValid && s_r.txIdx == 3'h0)
    else $error("retried head not resent");

  a_back_to_head: assert property (
    @(posedge sys_clk) disable iff (!resetn || !ce)
    seq_reordered_ok |-> ##2 s_r.txValid && s_r.txIdx == 3'h0)
    else $error("original packet not attempted again");

  a_resp_no_giveup: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    s_r.ans.giveUp |->
      s_r.ansUnit != UNIT_MAU && s_r.ansUnit != UNIT_RXU)
    else $error("response unit gave up");

  a_ls_code: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    s_r.ans.giveUp && s_r.ansUnit == UNIT_LSU |->
      s_r.lsCode == CODE_NO_CREDIT && s_r.ans.code == CODE_NO_CREDIT)
    else $error("load/store give-up without code");

  a_tx_skip: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    s_r.ans.giveUp && s_r.ansUnit == UNIT_TXU |->
      s_r.ans.skipQueue == s_r.ansFirst &&
      (s_r.ansFirst || s_r.ans.code == CODE_NO_CREDIT))
    else $error("message give-up handled wrongly");

  a_answer_onehot: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    $onehot0({s_r.ans.grant, s_r.ans.refuse, s_r.ans.giveUp}))
    else $error("credit answer not unique");

  a_offer_stable: assert property (
    @(posedge sys_clk) disable iff (!resetn || !ce)
    s_r.txValid && !txOk && !txRetry |=>
      s_r.txValid && $stable(s_r.txPkt))
    else $error("offered packet changed before outcome");

  a_ack_pulse: assert property (
    @(posedge sys_clk) disable iff (!resetn || !ce)
    s_r.wbAck |=> !s_r.wbAck)
    else $error("bus acknowledge longer than one cycle");

endmodule

// ### sim/tcrb_link_model.sv
// Behavioural model of the link partner that takes offered packets.
// Assumes txValid comes from the block on sys_clk; answers with random delay.
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Link partner model
// ------------------------------------------------------------------
module tcrb_link_model (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic hold,       // Stall: no answer while high
  input  wire logic retryNext,  // Answer the next offer with retry
  input  wire logic txValid,
  output      logic txOk,
  output      logic txRetry
);
  int unsigned waitCnt;          // Cycles still to wait before answering

  // One-cycle outcome pulse, then a fresh random delay of 0 to 2 cycles
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      txOk    <= 1'b0;
      txRetry <= 1'b0;
      waitCnt <= 0;
    end else if (txOk || txRetry) begin
      txOk    <= 1'b0;
      txRetry <= 1'b0;
      waitCnt <= $urandom_range(2, 0);
    end else if (txValid && !hold) begin
      if (waitCnt != 0) begin
        waitCnt <= waitCnt - 1;
      end else if (retryNext) begin
        txRetry <= 1'b1;
      end else begin
        txOk <= 1'b1;
      end
    end
  end
endmodule

// ### sim/tcrb_top_tb.sv
// Self-checking bench for the credit and reorder block.
// Assumes the package constants; short try counts 4 and 16.
`timescale 1ns/100ps

module tcrb_top_tb;
  import tcrb_pkg::*;
  logic        sys_clk, resetn, ce, txOk, txRetry, hold, wbAck, txValid;
  logic [31:0] wbDatOut, rd, setv, retryMask;
  logic [3:0]  bufRelease;
  logic [2:0]  lsStatusCode;
  logic [1:0]  p, nx;
  logic [1:0]  prioTab [8] = '{0, 0, 1, 2, 3, 3, 1, 0};
  int          ordTab [19] = '{0,4,0,5,0,1,2,3,6,7,7,8,9,10,11,12,13,14,15};
  tcrb_wbreq_t wbReq;
  tcrb_req_t   creditReq;
  tcrb_ans_t   creditAns;
  tcrb_pkt_t   txPkt;
  tcrb_ans_t   expAns [$];   // Expected credit answers, oldest first
  tcrb_pkt_t   expTx [$];    // Expected link offers, oldest first
  int          num_errors, n_checks, relCnt, grants;

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  tcrb_top #(.FIRST_TRIES(4), .LATER_TRIES(16)) tcrb_top_i (
    .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .wbReq(wbReq),
    .wbAck(wbAck), .wbDatOut(wbDatOut), .creditReq(creditReq),
    .creditAns(creditAns), .bufRelease(bufRelease), .txValid(txValid),
    .txPkt(txPkt), .txOk(txOk), .txRetry(txRetry),
    .lsStatusCode(lsStatusCode));

  tcrb_link_model tcrb_link_model_i (
    .sys_clk(sys_clk), .resetn(resetn), .hold(hold),
    .retryNext(retryMask[0]), .txValid(txValid), .txOk(txOk),
    .txRetry(txRetry));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic tcrb_ans_t mk(logic g, logic r, logic u, logic s,
                                   logic [2:0] c, logic [1:0] pr);
    mk = '{grant:g, refuse:r, giveUp:u, skipQueue:s, code:c, prio:pr};
  endfunction

  // Classic single Wishbone cycle; waits for ack under a bound
  task automatic wb(logic we, logic [7:0] a, logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    wbReq <= '{cyc:1'b1, stb:1'b1, we:we, adr:a, sel:4'hf, dat:d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      test_done();
    end
    q = wbDatOut;
    wbReq <= '0;
    @(posedge sys_clk);
  endtask

  // One credit request, two cycles apart, answer noted for the monitor
  task automatic credit(tcrb_unit_t u, logic [1:0] pr, logic [1:0] pt,
                        logic f, logic [7:0] t, tcrb_ans_t e);
    expAns.push_back(e);
    creditReq <= '{valid:1'b1, unit:u, prio:pr, port:pt, first:f, tag:t};
    @(posedge sys_clk);
    creditReq.valid <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic send(tcrb_unit_t u, logic [1:0] pr, logic [1:0] pt,
                      logic [7:0] t);
    credit(u, pr, pt, 1'b1, t, mk(1, 0, 0, 0, 0, pr));
    grants++;
  endtask

  // Refused tries until the last one, which ends with the given answer
  task automatic tries(tcrb_unit_t u, logic f, int n, tcrb_ans_t last);
    for (int i = 1; i < n; i++) begin
      credit(u, 2'h1, 2'h1, f, 8'(i), mk(0, 1, 0, 0, 0, 2'h1));
    end
    credit(u, 2'h1, 2'h1, f, 8'hff, last);
  endtask

  task automatic drain;
    int n;
    n = 0;
    while (expTx.size() != 0 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 2000) begin
      num_errors++;
      test_done();
    end
  endtask

  // ------------------------------------------------------------------
  // Output monitor: compares each result with the oldest note
  // ------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (resetn === 1'b1) begin
      relCnt += $countones(bufRelease);
      if ((creditAns.grant | creditAns.refuse |
           creditAns.giveUp) === 1'b1) begin
        if (expAns.size() != 0) chk(creditAns, expAns.pop_front());
        else chk(32'h1, 32'h0);
      end
      if ((txValid && (txOk || txRetry)) === 1'b1) begin
        if (expTx.size() != 0) chk(txPkt, expTx.pop_front());
        else chk(32'h1, 32'h0);
        retryMask <= retryMask >> 1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(87900));
    resetn = 1'b0;
    ce = 1'b1;
    hold = 1'b0;
    retryMask = '0;
    wbReq = '0;
    creditReq = '0;
    num_errors = 0;
    n_checks = 0;
    relCnt = 0;
    grants = 0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    // Reset values, read-only and unmapped places
    wb(0, ADR_SETTINGS, 0, rd);
    chk(rd, SETTINGS_RST);
    wb(0, ADR_CREDIT_STAT, 0, rd);
    chk(rd, 32'h0000_8888);
    wb(0, 8'h3c, 0, rd);
    chk(rd, 32'h0);
    wb(1, ADR_LS_STAT, 32'hffff_ffff, rd);
    wb(0, ADR_LS_STAT, 0, rd);
    chk(rd, 32'h0);
    setv = $urandom & 32'hffff_fe00;
    wb(1, ADR_SETTINGS, setv | 32'hff, rd);
    wb(0, ADR_SETTINGS, 0, rd);
    chk(rd, setv | 32'hff);
    $display("test registers done");
    // Thresholds at maximum: MAU, LSU and TXU requests are refused
    p = 2'h0;
    for (int i = 0; i < 4; i++) begin
      nx = (p == PRIO_MAX) ? PRIO_MAX : p + 2'h1;
      credit(UNIT_MAU, p, 2'h0, 1'b1, 8'(i), mk(0, 1, 0, 0, 0, nx));
      p = nx;
    end
    tries(UNIT_LSU, 1'b1, 4, mk(0, 0, 1, 0, CODE_NO_CREDIT, 1));
    @(posedge sys_clk);
    chk(lsStatusCode, CODE_NO_CREDIT);
    tries(UNIT_LSU, 1'b0, 16, mk(0, 0, 1, 0, CODE_NO_CREDIT, 2'h1));
    tries(UNIT_TXU, 1'b1, 4, mk(0, 0, 1, 1, 0, 2'h1));
    tries(UNIT_TXU, 1'b0, 16, mk(0, 0, 1, 0, CODE_NO_CREDIT, 2'h1));
    $display("test refusals done");
    // Free flow through every unit and port
    wb(1, ADR_SETTINGS, setv, rd);
    for (int u = 0; u < 4; u++) begin
      p = 2'($urandom);
      nx = 2'(u);
      expTx.push_back('{prio:p, tag:8'h80 + 8'(u)});
      send(tcrb_unit_t'(u), p, nx, 8'h80 + 8'(u));
    end
    drain();
    chk(lsStatusCode, 3'h0);
    $display("test free flow done");
    // Stalled link: fill port 0, then retries reorder
    hold <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      send(UNIT_MAU, (i < 8) ? prioTab[i] : 2'h0, 2'h0, 8'(i));
    end
    // Clock enable low: the bus access waits until it returns
    ce <= 1'b0;
    fork
      wb(0, ADR_CREDIT_STAT, 0, rd);
      begin
        repeat (2) @(posedge sys_clk);
        chk(wbAck, 1'b0);
        ce <= 1'b1;
      end
    join
    chk(rd, 32'h0008_8880);
    credit(UNIT_MAU, 2'h1, 2'h0, 1'b1, 8'h20, mk(0, 1, 0, 0, 0, 2'h2));
    foreach (ordTab[i]) begin
      p = (ordTab[i] < 8) ? prioTab[ordTab[i]] : 2'h0;
      expTx.push_back('{prio:p, tag:8'(ordTab[i])});
    end
    retryMask <= 32'h0000_0205;
    hold <= 1'b0;
    drain();
    $display("test reorder done");
    // Single port: groups per priority, highest drained first
    wb(1, ADR_SETTINGS, setv | 32'h100, rd);
    hold <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      expTx.push_back('{prio:2'h0, tag:8'h40 + 8'(i)});
      send(UNIT_RXU, 2'h0, 2'h0, 8'h40 + 8'(i));
    end
    for (int i = 0; i < 4; i++) begin
      send(UNIT_RXU, 2'(i), 2'h0, 8'h50 + 8'(i));
      expTx.push_back('{prio:2'(3 - i), tag:8'h53 - 8'(i)});
    end
    wb(0, ADR_CREDIT_STAT, 0, rd);
    chk(rd, 32'h0008_7777);
    hold <= 1'b0;
    drain();
    repeat (4) @(posedge sys_clk);
    chk(relCnt, grants);
    chk(expAns.size(), 0);
    $display("test single port done");
    test_done();
  end
endmodule
